// File: rtl/phy_strap_config_loader.sv
`timescale 1ns/1ps
`default_nettype none

module phy_strap_config_loader
  import strap_cfg_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock and bus reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Device reset and straps
  input  wire logic              device_reset,
  input  wire logic [ADDR_W-1:0] phy_address_switch,
  input  wire logic              mii_drive_strap,
  input  wire logic              autoneg_strap_zero_pd,
  input  wire logic              autoneg_strap_zero_pu,
  input  wire logic              autoneg_strap_one_pd,
  input  wire logic              autoneg_strap_one_pu,
  input  wire logic              tx_clock_mode_strap_pd,
  input  wire logic              tx_clock_mode_strap_pu,
  input  wire logic [MH_WIDTH-1:0] mode_strap_header,
  // Management frame address
  input  wire logic              mgmt_frame_valid,
  input  wire logic [ADDR_W-1:0] mgmt_phy_addr,
  output logic                   mgmt_addr_hit,
  output logic                   mgmt_enable,
  // MII pad control
  output logic                   mii_out_enable,
  output logic                   mii_rx_out_enable,
  output logic                   mii_drive_reduced,
  // Auto-negotiation setting
  output logic                   an_enable,
  output logic                   force_speed_100,
  output logic                   force_full_duplex,
  output logic [3:0]             an_advertise,
  // Transmit clock
  output logic                   tx_clk_drive_out,
  output logic                   reference_clock_out,
  // Operating modes
  output logic                   low_power,
  output logic                   crs_rx_only,
  output logic                   scrambler_bypass,
  output logic                   nrzi_fx_mode,
  output logic                   coder_bypass
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Auto-negotiation decode from the two three-state straps
  function automatic an_cfg_t an_decode(input tri_level_t a1, input tri_level_t a0);
    an_cfg_t c;
    c = '0;
    if (a1 == TRI_FLOAT && a0 == TRI_FLOAT) begin
      c.an_en    = 1'b1;
      c.speed100 = 1'b1;
      c.fdx      = 1'b1;
      c.adv      = ADV_ALL;
    end else if (a0 == TRI_FLOAT) begin
      c.speed100 = 1'b0;
      c.fdx      = (a1 == TRI_HIGH);
    end else if (a1 == TRI_FLOAT) begin
      c.speed100 = 1'b1;
      c.fdx      = (a0 == TRI_HIGH);
    end else begin
      c.an_en    = 1'b1;
      c.speed100 = (a1 == TRI_HIGH);
      c.fdx      = (a0 == TRI_HIGH);
      c.adv      = 4'(4'h1 << {c.speed100, c.fdx});
    end
    return c;
  endfunction

  // Address match: own address or broadcast zero
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] own);
    return (a == own) || (a == '0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Three-state strap decode

  strap_dec_if #(.N(TRI_COUNT)) dec_bus ();

  assign dec_bus.sense_pd = {tx_clock_mode_strap_pd, autoneg_strap_one_pd,
                             autoneg_strap_zero_pd};
  assign dec_bus.sense_pu = {tx_clock_mode_strap_pu, autoneg_strap_one_pu,
                             autoneg_strap_zero_pu};

  tri_strap_decoder #(.N(TRI_COUNT)) u_dec (
    .dec (dec_bus.decoder)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Strap sampling

  strap_state_t        state_r;
  logic [ADDR_W-1:0]   phy_addr_r;
  logic                drive_reduced_r;
  tri_level_t          an0_r;
  tri_level_t          an1_r;
  tri_level_t          tcm_r;
  logic [MH_WIDTH-1:0] mode_r;

  // Sample while reset is high, run afterwards
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_SAMPLE;
    end else begin
      unique case (state_r)
        ST_SAMPLE: if (!device_reset) state_r <= ST_RUN;
        ST_RUN:    if (device_reset) state_r <= ST_SAMPLE;
      endcase
    end
  end

  // Latch straps during reset, hold them after release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_addr_r      <= PHY_ADDR_RESET;
      drive_reduced_r <= 1'b0;
      an0_r           <= TRI_FLOAT;
      an1_r           <= TRI_FLOAT;
      tcm_r           <= TRI_FLOAT;
      mode_r          <= '0;
    end else if (device_reset) begin
      phy_addr_r      <= phy_address_switch;
      drive_reduced_r <= mii_drive_strap;
      an0_r           <= dec_bus.level[TRI_AN0];
      an1_r           <= dec_bus.level[TRI_AN1];
      tcm_r           <= dec_bus.level[TRI_TCM];
      mode_r          <= mode_strap_header;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  logic        hreadyout_r;
  logic [31:0] hrdata_r;
  logic        hresp_r;
  logic        dp_write_r;
  logic        rd_pend_r;
  logic [7:0]  dp_addr_r;
  logic        isolate_r;
  logic        low_power_req_r;
  logic        refclk_off_r;
  logic        accept;
  logic        wr_commit;
  an_cfg_t     an_cfg;
  logic        an_enable_r;
  logic        speed100_r;
  logic        fdx_r;
  logic [3:0]  adv_r;
  logic        tx_clk_out_r;
  logic        ref_en_r;
  logic        low_power_r;
  logic        rx_oe_r;
  logic        mii_oe_r;
  logic        mgmt_en_r;
  logic        hit_r;
  logic        mode_crs_r;
  logic        mode_scr_r;
  logic        mode_coder_r;

  assign accept    = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign wr_commit = dp_write_r && hreadyout_r;

  // Address phase capture; reads add one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_r  <= 1'b0;
      rd_pend_r   <= 1'b0;
      dp_addr_r   <= '0;
      hreadyout_r <= 1'b1;
      hresp_r     <= HRESP_OKAY;
    end else begin
      hresp_r <= HRESP_OKAY;
      if (rd_pend_r) begin
        rd_pend_r   <= 1'b0;
        hreadyout_r <= 1'b1;
      end else if (accept) begin
        dp_addr_r   <= haddr[7:0];
        dp_write_r  <= hwrite;
        rd_pend_r   <= !hwrite;
        hreadyout_r <= hwrite;
      end else begin
        dp_write_r  <= 1'b0;
      end
    end
  end

  // Read data from the decoded register; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (rd_pend_r) begin
      hrdata_r <= '0;
      unique case (dp_addr_r)
        ADDR_BASIC_CTRL: begin
          hrdata_r[BC_ISOLATE_BIT]   <= isolate_r;
          hrdata_r[BC_LOW_POWER_BIT] <= low_power_req_r;
        end
        ADDR_STRAP_STATUS: begin
          hrdata_r[ADDR_W-1:0] <= phy_addr_r;
          hrdata_r[5]          <= drive_reduced_r;
          hrdata_r[7:6]        <= an0_r;
          hrdata_r[9:8]        <= an1_r;
          hrdata_r[11:10]      <= tcm_r;
          hrdata_r[17:12]      <= mode_r;
        end
        ADDR_MODE_STATUS: begin
          hrdata_r[0]   <= an_enable_r;
          hrdata_r[1]   <= speed100_r;
          hrdata_r[2]   <= fdx_r;
          hrdata_r[6:3] <= adv_r;
          hrdata_r[7]   <= tx_clk_out_r;
          hrdata_r[8]   <= ref_en_r;
          hrdata_r[9]   <= low_power_r;
          hrdata_r[10]  <= !rx_oe_r;
        end
        ADDR_SUBLAYER: hrdata_r[SL_REFCLK_OFF] <= refclk_off_r;
        default: hrdata_r <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits: strap set at reset wins over software clear

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      isolate_r       <= 1'b0;
      low_power_req_r <= 1'b0;
    end else if (device_reset) begin
      isolate_r       <= (phy_address_switch == '0);
      low_power_req_r <= mode_strap_header[MH_LP_START];
    end else if (wr_commit && dp_addr_r == ADDR_BASIC_CTRL) begin
      isolate_r       <= hwdata[BC_ISOLATE_BIT];
      low_power_req_r <= hwdata[BC_LOW_POWER_BIT];
    end
  end

  // Sublayer clock-output control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      refclk_off_r <= REFCLK_OFF_RESET;
    end else if (wr_commit && dp_addr_r == ADDR_SUBLAYER) begin
      refclk_off_r <= hwdata[SL_REFCLK_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied configuration

  assign an_cfg = an_decode(an1_r, an0_r);

  // Auto-negotiation and clock mode from held straps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      an_enable_r  <= 1'b0;
      speed100_r   <= 1'b0;
      fdx_r        <= 1'b0;
      adv_r        <= '0;
      tx_clk_out_r <= 1'b0;
      ref_en_r     <= 1'b0;
    end else begin
      an_enable_r  <= an_cfg.an_en;
      speed100_r   <= an_cfg.speed100;
      fdx_r        <= an_cfg.fdx;
      adv_r        <= an_cfg.adv;
      tx_clk_out_r <= (tcm_r == TRI_LOW);
      ref_en_r     <= (tcm_r == TRI_HIGH) || !refclk_off_r;
    end
  end

  // Power, pad enables and datapath modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_power_r  <= 1'b0;
      mgmt_en_r    <= 1'b0;
      mii_oe_r     <= 1'b0;
      rx_oe_r      <= 1'b0;
      mode_crs_r   <= 1'b0;
      mode_scr_r   <= 1'b0;
      mode_coder_r <= 1'b0;
    end else begin
      low_power_r  <= low_power_req_r
                      || mode_strap_header[MH_POWER_DOWN];
      mgmt_en_r    <= !mode_strap_header[MH_POWER_DOWN];
      mii_oe_r     <= !isolate_r && state_r == ST_RUN;
      rx_oe_r      <= !isolate_r && state_r == ST_RUN
                      && !mode_strap_header[MH_RX_DISABLE];
      mode_crs_r   <= mode_r[MH_CRS_MODE];
      mode_scr_r   <= mode_r[MH_SCR_BYPASS];
      mode_coder_r <= mode_r[MH_CODER_BYPASS];
    end
  end

  // Management address decode, one cycle after the frame strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= mgmt_frame_valid && mgmt_en_r
               && addr_hit(mgmt_phy_addr, phy_addr_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock divider

  logic [3:0] ref_cnt_r;
  logic       ref_clk_r;

  // Toggle every half period while enabled, else hold low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt_r <= '0;
      ref_clk_r <= 1'b0;
    end else if (!ref_en_r) begin
      ref_cnt_r <= '0;
      ref_clk_r <= 1'b0;
    end else if (ref_cnt_r == 4'(REF_HALF_CYCLES - 1)) begin
      ref_cnt_r <= '0;
      ref_clk_r <= !ref_clk_r;
    end else begin
      ref_cnt_r <= ref_cnt_r + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hreadyout           = hreadyout_r;
  assign hresp               = hresp_r;
  assign hrdata              = hrdata_r;
  assign mgmt_addr_hit       = hit_r;
  assign mgmt_enable         = mgmt_en_r;
  assign mii_out_enable      = mii_oe_r;
  assign mii_rx_out_enable   = rx_oe_r;
  assign mii_drive_reduced   = drive_reduced_r;
  assign an_enable           = an_enable_r;
  assign force_speed_100     = speed100_r;
  assign force_full_duplex   = fdx_r;
  assign an_advertise        = adv_r;
  assign tx_clk_drive_out    = tx_clk_out_r;
  assign reference_clock_out = ref_clk_r;
  assign low_power           = low_power_r;
  assign crs_rx_only         = mode_crs_r;
  assign scrambler_bypass    = mode_scr_r;
  assign nrzi_fx_mode        = mode_scr_r;
  assign coder_bypass        = mode_coder_r;

endmodule

`default_nettype wire

// File: rtl/strap_cfg_pkg.sv
package strap_cfg_pkg;

  // Three-state strap levels
  typedef enum logic [1:0] {
    TRI_LOW   = 2'h0,
    TRI_FLOAT = 2'h1,
    TRI_HIGH  = 2'h3
  } tri_level_t;

  // Strap sampling state, Gray along sample to run
  typedef enum logic [1:0] {
    ST_SAMPLE = 2'h0,
    ST_RUN    = 2'h1
  } strap_state_t;

  // Decoded auto-negotiation setting
  typedef struct packed {
    logic       an_en;
    logic       speed100;
    logic       fdx;
    logic [3:0] adv;   // [0]10H [1]10F [2]100H [3]100F
  } an_cfg_t;

  // Three-state strap slots in the decoder
  localparam int TRI_COUNT    = 3;
  localparam int TRI_AN0      = 0;
  localparam int TRI_AN1      = 1;
  localparam int TRI_TCM      = 2;

  // Mode header pin-pair positions
  localparam int MH_WIDTH        = 6;
  localparam int MH_LP_START     = 0;
  localparam int MH_RX_DISABLE   = 1;
  localparam int MH_POWER_DOWN   = 2;
  localparam int MH_CRS_MODE     = 3;
  localparam int MH_SCR_BYPASS   = 4;
  localparam int MH_CODER_BYPASS = 5;

  // Register byte addresses and the sublayer register index
  localparam logic [7:0] SUBLAYER_INDEX    = 8'h17;
  localparam logic [7:0] ADDR_BASIC_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STRAP_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MODE_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_SUBLAYER     = 8'(SUBLAYER_INDEX * 4);

  // Field positions
  localparam int BC_ISOLATE_BIT   = 10;
  localparam int BC_LOW_POWER_BIT = 11;
  localparam int SL_REFCLK_OFF    = 7;

  // Reset values and the full advertisement mask
  localparam logic [4:0] PHY_ADDR_RESET     = 5'h00;
  localparam logic       REFCLK_OFF_RESET   = 1'b1;
  localparam logic [3:0] ADV_ALL            = 4'hF;

  // Timing: core clock and reference clock output
  localparam longint CORE_CLK_HZ     = 200_000_000;
  localparam longint REF_CLK_HZ      = 25_000_000;
  localparam int     REF_HALF_CYCLES = int'(CORE_CLK_HZ / (2 * REF_CLK_HZ));

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// File: rtl/strap_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface strap_dec_if
  import strap_cfg_pkg::*;
#(
  parameter int N = TRI_COUNT
);
  logic [N-1:0] sense_pd;  // Pin level seen with weak pull-down
  logic [N-1:0] sense_pu;  // Pin level seen with weak pull-up
  tri_level_t   level [N];

  modport source  (output sense_pd, output sense_pu, input level);
  modport decoder (input sense_pd, input sense_pu, output level);
endinterface

`default_nettype wire

// File: rtl/tri_strap_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module tri_strap_decoder
  import strap_cfg_pkg::*;
#(
  parameter int N = TRI_COUNT
) (
  // Sense inputs and decoded levels
  strap_dec_if.decoder dec
);

  // Pin follows the pull when floating, else it is driven
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (dec.sense_pd[i] && dec.sense_pu[i]) begin
        dec.level[i] = TRI_HIGH;
      end else if (!dec.sense_pd[i] && !dec.sense_pu[i]) begin
        dec.level[i] = TRI_LOW;
      end else begin
        dec.level[i] = TRI_FLOAT;
      end
    end
  end

endmodule

`default_nettype wire

// File: sim/phy_strap_config_loader_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module phy_strap_config_loader_tb_top
  import strap_cfg_pkg::*;
;
  logic                hclk, hresetn, hsel, hwrite, device_reset, mii_drive_strap;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [4:0]          phy_address_switch, mgmt_phy_addr, own;
  logic [MH_WIDTH-1:0] mode_strap_header, m;
  logic                mgmt_frame_valid, drv, hreadyout, hresp, mgmt_addr_hit, mgmt_enable;
  logic                a0d, a0u, a1d, a1u, tcd, tcu, mii_out_enable, mii_rx_out_enable;
  logic                mii_drive_reduced, an_enable, force_speed_100, force_full_duplex;
  logic [3:0]          an_advertise;
  logic                tx_clk_drive_out, reference_clock_out, low_power, crs_rx_only;
  logic                scrambler_bypass, nrzi_fx_mode, coder_bypass;
  logic [6:0]          ex;
  tri_level_t          an0_lv, an1_lv, tcm_lv, l0, l1;
  tri_level_t          lv [3] = '{TRI_LOW, TRI_FLOAT, TRI_HIGH};
  int                  bad_count = 0;
  int                  checked = 0;
  int                  n;

  ////////////////////////////////////////////////////////////////////////////
  // Design, board jumpers
  phy_strap_config_loader DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .device_reset, .phy_address_switch, .mii_drive_strap,
    .autoneg_strap_zero_pd(a0d), .autoneg_strap_zero_pu(a0u), .autoneg_strap_one_pd(a1d),
    .autoneg_strap_one_pu(a1u), .tx_clock_mode_strap_pd(tcd), .tx_clock_mode_strap_pu(tcu),
    .mode_strap_header, .mgmt_frame_valid, .mgmt_phy_addr, .mgmt_addr_hit, .mgmt_enable,
    .mii_out_enable, .mii_rx_out_enable, .mii_drive_reduced, .an_enable, .force_speed_100,
    .force_full_duplex, .an_advertise, .tx_clk_drive_out, .reference_clock_out, .low_power,
    .crs_rx_only, .scrambler_bypass, .nrzi_fx_mode, .coder_bypass
  );
  strap_board_model board (
    .an0_lv, .an1_lv, .tcm_lv, .an0_pd(a0d), .an0_pu(a0u), .an1_pd(a1d), .an1_pu(a1u),
    .tcm_pd(tcd), .tcm_pu(tcu)
  );

  // Clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One single AHB transfer, address phase then data phase
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] q);
    int k;
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= HTRANS_NONSEQ;
    k = 0;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 100);
    q = hrdata;
    if (k >= 100) begin
      bad_count++;
      end_sim();
    end
  endtask

  // Pulse the device reset with straps already placed
  task automatic strap_reset();
    device_reset <= 1'b1;
    repeat (3) @(posedge hclk);
    device_reset <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask

  task automatic mgmt(input logic [4:0] a, input logic e);
    mgmt_frame_valid <= 1'b1; mgmt_phy_addr <= a;
    @(posedge hclk);
    mgmt_frame_valid <= 1'b0;
    @(posedge hclk);
    chk(mgmt_addr_hit, e, "mgmt hit");
  endtask

  // Rising edges of the reference clock over 40 cycles
  task automatic rises(output int c);
    logic p;
    c = 0;
    repeat (8) @(posedge hclk);
    p = reference_clock_out;
    repeat (40) begin
      @(posedge hclk);
      if (reference_clock_out === 1'b1 && p === 1'b0) c++;
      p = reference_clock_out;
    end
  endtask

  // Model: {an_en, speed100, fdx, advertise}
  function automatic logic [6:0] exp_an(tri_level_t s1, tri_level_t s0);
    logic f, s;
    f = (s0 == TRI_HIGH);
    s = (s1 == TRI_HIGH);
    if (s1 == TRI_FLOAT && s0 == TRI_FLOAT) return 7'h7F;
    if (s0 == TRI_FLOAT) return {2'b00, s, 4'h0};
    if (s1 == TRI_FLOAT) return {2'b01, f, 4'h0};
    return {1'b1, s, f, 4'(1 << {s, f})};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = '0; device_reset = 1'b0; phy_address_switch = '0; mii_drive_strap = 1'b0;
    mode_strap_header = '0; mgmt_frame_valid = 1'b0; mgmt_phy_addr = '0;
    an0_lv = TRI_FLOAT; an1_lv = TRI_FLOAT; tcm_lv = TRI_FLOAT;
    void'($urandom(32'h9fbb));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(ADDR_SUBLAYER, 1'b0, '0, rd);
    chk(rd[SL_REFCLK_OFF], 1'b1, "sublayer reset");
    ahb(8'h40, 1'b1, 32'hFFFF_FFFF, rd);
    ahb(8'h40, 1'b0, '0, rd);
    chk(rd, 32'h0, "unmapped");
    $display("test bus done");
    for (int i = 0; i < 9; i++) begin
      l1 = lv[i / 3];
      l0 = lv[i % 3];
      if (i > 0) begin
        an0_lv <= l0; an1_lv <= l1; tcm_lv <= l0; phy_address_switch <= ~own;
        mii_drive_strap <= ~drv; mode_strap_header <= ~m & 6'h3B;
        repeat (4) @(posedge hclk);
        chk({an_enable, force_speed_100, force_full_duplex, an_advertise}, ex, "held an");
        chk({mii_drive_reduced, crs_rx_only}, {drv, m[3]}, "held straps");
        mgmt(own, 1'b1);
      end
      own = 5'($urandom_range(30, 1));
      drv = 1'($urandom);
      m = 6'($urandom) & 6'h3B;
      an0_lv <= l0; an1_lv <= l1; tcm_lv <= l0; phy_address_switch <= own;
      mii_drive_strap <= drv; mode_strap_header <= m;
      strap_reset();
      ex = exp_an(l1, l0);
      chk({an_enable, force_speed_100, force_full_duplex, an_advertise}, ex, "an");
      chk(tx_clk_drive_out, l0 == TRI_LOW, "tx clk mode");
      chk({mii_drive_reduced, mii_out_enable}, {drv, 1'b1}, "drive");
      chk({crs_rx_only, scrambler_bypass, nrzi_fx_mode, coder_bypass},
          {m[3], m[4], m[4], m[5]}, "modes");
      chk({low_power, mii_rx_out_enable}, {m[0], ~m[1]}, "power rx");
      ahb(ADDR_STRAP_STATUS, 1'b0, '0, rd);
      chk(rd[17:0], {m, l0, l1, l0, drv, own}, "strap status");
      ahb(ADDR_MODE_STATUS, 1'b0, '0, rd);
      chk(rd[6:0], {ex[3:0], ex[4], ex[5], ex[6]}, "mode status");
      chk(rd[8:7], {l0 == TRI_HIGH, l0 == TRI_LOW}, "clock status");
      mgmt(own, 1'b1);
      mgmt(5'h00, 1'b1);
      mgmt(~own, 1'b0);
      rises(n);
      chk(n, (l0 == TRI_HIGH) ? 5 : 0, "refclk");
      $display("test straps %0d done", i);
    end
    phy_address_switch <= 5'h00; tcm_lv <= TRI_LOW; mode_strap_header <= '0;
    strap_reset();
    chk(mii_out_enable, 1'b0, "isolated");
    ahb(ADDR_BASIC_CTRL, 1'b0, '0, rd);
    chk(rd[BC_ISOLATE_BIT], 1'b1, "isolate bit");
    mgmt(5'h00, 1'b1);
    rises(n);
    chk(n, 0, "refclk off");
    ahb(ADDR_SUBLAYER, 1'b1, '0, rd);
    rises(n);
    chk(n, 5, "refclk forced");
    ahb(ADDR_BASIC_CTRL, 1'b1, '0, rd);
    repeat (3) @(posedge hclk);
    chk(mii_out_enable, 1'b1, "isolate cleared");
    mode_strap_header <= 6'h06;
    repeat (3) @(posedge hclk);
    chk({low_power, mgmt_enable, mii_rx_out_enable}, 3'b100, "power down");
    mgmt(5'h00, 1'b0);
    mode_strap_header <= '0;
    repeat (3) @(posedge hclk);
    chk({low_power, mgmt_enable}, 2'b01, "power up");
    $display("test isolate done");
    end_sim();
  end
endmodule

`default_nettype wire

// File: sim/strap_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module strap_board_model
  import strap_cfg_pkg::*;
(
  // Jumper positions of the three-state headers
  input  wire tri_level_t an0_lv,
  input  wire tri_level_t an1_lv,
  input  wire tri_level_t tcm_lv,
  // Pin levels as sensed through weak pulls
  output logic            an0_pd,
  output logic            an0_pu,
  output logic            an1_pd,
  output logic            an1_pu,
  output logic            tcm_pd,
  output logic            tcm_pu
);
  ////////////////////////////////////////////////////////////////////////////
  // Low jumper wins both pulls, high jumper too, open pin follows the pull
  assign an0_pd = (an0_lv == TRI_HIGH);
  assign an0_pu = (an0_lv != TRI_LOW);
  assign an1_pd = (an1_lv == TRI_HIGH);
  assign an1_pu = (an1_lv != TRI_LOW);
  assign tcm_pd = (tcm_lv == TRI_HIGH);
  assign tcm_pu = (tcm_lv != TRI_LOW);
endmodule

`default_nettype wire

// File: sim/strap_loader_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module strap_loader_monitor
  import strap_cfg_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock, reset and bus
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic                hready,
  input  wire logic                hreadyout,
  input  wire logic                hresp,
  // Straps and management
  input  wire logic                device_reset,
  input  wire logic [MH_WIDTH-1:0] mode_strap_header,
  input  wire logic                mgmt_frame_valid,
  input  wire logic [ADDR_W-1:0]   mgmt_phy_addr,
  input  wire logic                mgmt_addr_hit,
  input  wire logic                mgmt_enable,
  // Pads and modes
  input  wire logic                mii_out_enable,
  input  wire logic                mii_rx_out_enable,
  input  wire logic                mii_drive_reduced,
  input  wire logic                low_power,
  input  wire logic                reference_clock_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing
  wire take = hsel && hready && (htrans == HTRANS_NONSEQ);
  resp_okay_a: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout) else $error("write waited");

  // Management address match
  bcast_hit_a: assert property (mgmt_frame_valid && mgmt_enable && mgmt_phy_addr == '0
    |=> mgmt_addr_hit) else $error("broadcast missed");
  hit_pulse_a: assert property (!mgmt_frame_valid |=> !mgmt_addr_hit)
    else $error("hit without frame");
  mgmt_stop_a: assert property (mgmt_frame_valid && !mgmt_enable |=> !mgmt_addr_hit)
    else $error("hit while stopped");

  // Live header inputs
  power_down_a: assert property (mode_strap_header[MH_POWER_DOWN]
    |=> low_power && !mgmt_enable) else $error("power down ignored");
  rx_tristate_a: assert property (mode_strap_header[MH_RX_DISABLE]
    |=> !mii_rx_out_enable) else $error("rx not tristated");

  // Sampling and holding
  sample_isolate_a: assert property (device_reset [*3] |-> !mii_out_enable)
    else $error("mii driven in reset");
  drive_held_a: assert property (!$past(device_reset, 2) && !$past(device_reset)
    && !device_reset |-> $stable(mii_drive_reduced)) else $error("drive strap not held");
  refclk_half_a: assert property (disable iff (!hresetn || device_reset)
    $rose(reference_clock_out) |-> reference_clock_out [*4] ##1 !reference_clock_out)
    else $error("refclk period");

  // Main scenarios
  cover property (mgmt_frame_valid && mgmt_phy_addr == '0 ##1 mgmt_addr_hit);
  cover property ($rose(reference_clock_out));
  cover property (take && !hwrite);
endmodule

bind phy_strap_config_loader strap_loader_monitor #(.ADDR_W(ADDR_W)) mon (
  .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .device_reset,
  .mode_strap_header, .mgmt_frame_valid, .mgmt_phy_addr, .mgmt_addr_hit, .mgmt_enable,
  .mii_out_enable, .mii_rx_out_enable, .mii_drive_reduced, .low_power, .reference_clock_out
);

`default_nettype wire
